// ==== bcs_counter.sv ====
// three-decade bcd counter with capture latches and digit scanner
// Contract
// [RULE_01] clear resets counters and scanner
// [RULE_02] clear holds scanner on first digit
// [RULE_03] clear drives all digit selects inactive
// [RULE_04] clear stops scan clock advance
// [RULE_05] disable blocks count edges, keeps value
// [RULE_06] capture rising edge latches, holds while high
// [RULE_07] hold capture through clear keeps latched value
// [RULE_08] falling count edge, synchronous decade chain
// [RULE_09] bcd active high, selects active low
// [RULE_10] one overflow pulse per thousand counts
// [RULE_11] internal scan tick or external override
// [RULE_12] scanner cycles digits one, two, three
`timescale 1ns/1ns
module bcs_counter
  import bcs_pkg::*;
#(
  parameter int SCAN_DIV = BCS_SCAN_DIV
)(
  input  wire logic       CORE_CLK,
  input  wire logic       RST_N,
  input  wire logic       COUNT_IN,
  input  wire logic       COUNT_DISABLE,
  input  wire logic       COUNT_CLEAR,
  input  wire logic       CAPTURE_HOLD,
  input  wire logic       SCAN_EXT_SEL,
  input  wire logic       SCAN_EXT_CLK,
  output logic [3:0]      BCD_OUT,
  output logic [2:0]      DIGIT_SEL_N,
  output logic            OVERFLOW
);
  if (SCAN_DIV < 2) begin
    $error("SCAN_DIV must be at least 2");
  end

  // ==========================================================
  // input edge detection
  logic          count_prev;
  logic          capture_prev;
  logic          ext_prev;
  wire logic     count_fall;
  wire logic     capture_rise;
  wire logic     ext_rise;
  wire logic     count_step;

  // [RULE_08] falling count edge
  assign count_fall   = count_prev && !COUNT_IN;
  assign capture_rise = CAPTURE_HOLD && !capture_prev;
  assign ext_rise     = SCAN_EXT_CLK && !ext_prev;
  // [RULE_05] disable gates the edge
  assign count_step   = count_fall && !COUNT_DISABLE && !COUNT_CLEAR;

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      count_prev   <= 1'b0;
      capture_prev <= 1'b0;
      ext_prev     <= 1'b0;
    end else begin
      count_prev   <= COUNT_IN;
      capture_prev <= CAPTURE_HOLD;
      ext_prev     <= SCAN_EXT_CLK;
    end
  end

  // ==========================================================
  // decade chain
  bcs_count_type count;
  wire logic     roll0;
  wire logic     roll1;
  wire logic     roll2;

  // [RULE_08] synchronous carry chain
  bcs_decade u_d0 (
    .clk   (CORE_CLK),
    .rst_n (RST_N),
    .clear (COUNT_CLEAR),
    .step  (count_step),
    .value (count.d0),
    .roll  (roll0)
  );
  bcs_decade u_d1 (
    .clk   (CORE_CLK),
    .rst_n (RST_N),
    .clear (COUNT_CLEAR),
    .step  (roll0),
    .value (count.d1),
    .roll  (roll1)
  );
  bcs_decade u_d2 (
    .clk   (CORE_CLK),
    .rst_n (RST_N),
    .clear (COUNT_CLEAR),
    .step  (roll1),
    .value (count.d2),
    .roll  (roll2)
  );

  // [RULE_10] overflow pulse on full rollover
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      OVERFLOW <= 1'b0;
    end else begin
      OVERFLOW <= roll2;
    end
  end

  // ==========================================================
  // capture latches
  bcs_count_type latched;
  bcs_count_type shown;

  // latch is transparent while low so the display tracks the count
  // [RULE_06] freeze on rising capture edge
  // [RULE_07] held value survives a clear
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      latched <= '0;
    end else if (!CAPTURE_HOLD || capture_rise) begin
      latched <= count;
    end
  end
  assign shown = latched;

  // ==========================================================
  // scan tick source
  logic [$clog2(SCAN_DIV)-1:0] div_cnt;
  wire logic                   int_tick;
  wire logic                   scan_tick;

  assign int_tick = (div_cnt == '0);
  // [RULE_11] internal divider or external override
  // [RULE_04] tick inhibited during clear
  assign scan_tick = (SCAN_EXT_SEL ? ext_rise : int_tick) && !COUNT_CLEAR;

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      div_cnt <= '0;
    end else if (COUNT_CLEAR || int_tick) begin
      div_cnt <= ($clog2(SCAN_DIV))'(SCAN_DIV - 1);
    end else begin
      div_cnt <= div_cnt - 1'b1;
    end
  end

  // ==========================================================
  // digit scanner
  bcs_scan_type scan;
  bcs_scan_type next_scan;

  // [RULE_12] cyclic digit order
  always_comb begin
    case (scan)
      BCS_SCAN_D0: next_scan = BCS_SCAN_D1;
      BCS_SCAN_D1: next_scan = BCS_SCAN_D2;
      BCS_SCAN_D2: next_scan = BCS_SCAN_D0;
      default:     next_scan = BCS_SCAN_D0;
    endcase
  end

  // [RULE_01] clear resets scanner
  // [RULE_02] parked on first digit
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      scan <= BCS_SCAN_D0;
    end else if (COUNT_CLEAR) begin
      scan <= BCS_SCAN_D0;
    end else if (scan_tick) begin
      scan <= next_scan;
    end
  end

  wire logic [3:0] next_bcd;
  wire logic [2:0] next_sel_n;

  // [RULE_09] active high nibble, active low select
  assign next_bcd = (scan == BCS_SCAN_D2) ? shown.d2 :
                    (scan == BCS_SCAN_D1) ? shown.d1 : shown.d0;
  // [RULE_03] selects off during clear
  assign next_sel_n = COUNT_CLEAR            ? BCS_SEL_IDLE :
                      (scan == BCS_SCAN_D2)  ? 3'h3 :
                      (scan == BCS_SCAN_D1)  ? 3'h5 : 3'h6;

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      BCD_OUT     <= 4'h0;
      DIGIT_SEL_N <= BCS_SEL_IDLE;
    end else begin
      BCD_OUT     <= next_bcd;
      DIGIT_SEL_N <= next_sel_n;
    end
  end

  // ==========================================================
  // checks
  sequence clear_seq;
    COUNT_CLEAR ##1 COUNT_CLEAR;
  endsequence

  clear_sel_off_a: assert property ( // [RULE_03]
    @(posedge CORE_CLK) disable iff (!RST_N)
    COUNT_CLEAR |=> DIGIT_SEL_N == BCS_SEL_IDLE)
    else $error("digit select active during clear");
  clear_zero_a: assert property ( // [RULE_01]
    @(posedge CORE_CLK) disable iff (!RST_N)
    COUNT_CLEAR |=> count == '0)
    else $error("count not cleared");
  clear_park_a: assert property ( // [RULE_02]
    @(posedge CORE_CLK) disable iff (!RST_N)
    clear_seq |-> scan == BCS_SCAN_D0)
    else $error("scanner not parked");
  // divider and selector both frozen once clear has settled
  scan_stop_a: assert property ( // [RULE_04]
    @(posedge CORE_CLK) disable iff (!RST_N)
    clear_seq ##1 COUNT_CLEAR |-> $stable(scan) && $stable(div_cnt))
    else $error("scan advanced during clear");
  disable_hold_a: assert property ( // [RULE_05]
    @(posedge CORE_CLK) disable iff (!RST_N)
    COUNT_DISABLE && !COUNT_CLEAR |=> count == $past(count))
    else $error("count moved while disabled");
  latch_hold_a: assert property ( // [RULE_06]
    @(posedge CORE_CLK) disable iff (!RST_N)
    CAPTURE_HOLD && capture_prev |=> latched == $past(latched))
    else $error("latch changed while held");
  latch_keep_a: assert property ( // [RULE_07]
    @(posedge CORE_CLK) disable iff (!RST_N)
    CAPTURE_HOLD && capture_prev && COUNT_CLEAR ##1 CAPTURE_HOLD
      |-> latched == $past(latched))
    else $error("latched value lost across clear");
  count_step_a: assert property ( // [RULE_08]
    @(posedge CORE_CLK) disable iff (!RST_N)
    count_step && count.d0 != BCS_DIGIT_MAX
      |=> count.d0 == $past(count.d0) + 4'h1)
    else $error("count did not advance");
  overflow_a: assert property ( // [RULE_10]
    @(posedge CORE_CLK) disable iff (!RST_N)
    count_step && count == 12'h999 |=> OVERFLOW ##1 !OVERFLOW)
    else $error("overflow pulse wrong");
  scan_order_a: assert property ( // [RULE_12]
    @(posedge CORE_CLK) disable iff (!RST_N)
    scan_tick && scan == BCS_SCAN_D2 |=> scan == BCS_SCAN_D0)
    else $error("scan order wrong");
  // selects still show reset idle at the first edge after release
  sel_one_a: assert property ( // [RULE_09]
    @(posedge CORE_CLK) disable iff (!RST_N)
    $past(RST_N) && !$past(COUNT_CLEAR) |-> $countones(~DIGIT_SEL_N) == 1)
    else $error("not exactly one select");
endmodule

// ==== bcs_decade.sv ====
// one bcd decade stage with carry in and carry out
`timescale 1ns/1ns
module bcs_decade
  import bcs_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       clear,
  input  wire logic       step,
  output logic [3:0]      value,
  output wire logic       roll
);
  logic [3:0] next_value;

  assign roll       = step && (value == BCS_DIGIT_MAX);
  assign next_value = roll ? BCS_DIGIT_RST : value + 4'h1;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      value <= BCS_DIGIT_RST;
    end else if (clear) begin
      value <= BCS_DIGIT_RST;
    end else if (step) begin
      value <= next_value;
    end
  end
endmodule

// ==== bcs_pkg.sv ====
// shared constants and carrier types for the bcd counter/scanner
package bcs_pkg;
  localparam int          BCS_DIGITS      = 3;
  localparam logic [3:0]  BCS_DIGIT_MAX   = 4'h9;
  localparam logic [3:0]  BCS_DIGIT_RST   = 4'h0;
  localparam logic [2:0]  BCS_SEL_IDLE    = 3'h7;
  // default scan rate in Hz and derived divider count at 250 MHz core clock
  localparam int          BCS_CLK_HZ      = 250000000;
  localparam int          BCS_SCAN_HZ     = 1000;
  localparam int          BCS_SCAN_DIV    = BCS_CLK_HZ / BCS_SCAN_HZ;

  typedef struct packed {
    logic [3:0] d2;
    logic [3:0] d1;
    logic [3:0] d0;
  } bcs_count_type;

  typedef enum logic [1:0] {
    BCS_SCAN_D0,
    BCS_SCAN_D1,
    BCS_SCAN_D2
  } bcs_scan_type;
endpackage

// ==== bcs_source.sv ====
// pulse source and external scan clock model for the counter bench
`timescale 1ns/1ns
module bcs_source (
  input  wire logic clk,
  input  wire logic ext_run,
  output logic      count_in,
  output logic      ext_clk
);
  logic [1:0] div;
  initial begin
    count_in = 1'b0;
    ext_clk  = 1'b0;
    div      = 2'h0;
  end
  // external scan override
  // ext clock stands still unless the bench runs it
  always @(posedge clk) begin
    div <= div + 2'h1;
    if (ext_run && div == 2'h3) ext_clk <= ~ext_clk;
  end
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clk) count_in <= 1'b1;
      @(posedge clk) count_in <= 1'b0;
    end
  endtask
endmodule

// ==== testbench.sv ====
// self-checking bench for the bcd counter with scanner
`timescale 1ns/1ns
module testbench;
  import bcs_pkg::*;
  logic       CORE_CLK, RST_N, COUNT_DISABLE, COUNT_CLEAR;
  logic       CAPTURE_HOLD, SCAN_EXT_SEL, ext_run;
  wire logic  COUNT_IN, SCAN_EXT_CLK;
  logic [3:0] BCD_OUT;
  logic [2:0] DIGIT_SEL_N;
  logic       OVERFLOW;
  int         n_fail, checks_done, n_ovf;
  bcs_source src (.clk(CORE_CLK), .ext_run(ext_run), .count_in(COUNT_IN),
                  .ext_clk(SCAN_EXT_CLK));
  bcs_counter #(.SCAN_DIV(4)) uut (.CORE_CLK(CORE_CLK), .RST_N(RST_N),
    .COUNT_IN(COUNT_IN), .COUNT_DISABLE(COUNT_DISABLE),
    .COUNT_CLEAR(COUNT_CLEAR), .CAPTURE_HOLD(CAPTURE_HOLD),
    .SCAN_EXT_SEL(SCAN_EXT_SEL), .SCAN_EXT_CLK(SCAN_EXT_CLK),
    .BCD_OUT(BCD_OUT), .DIGIT_SEL_N(DIGIT_SEL_N), .OVERFLOW(OVERFLOW));
  // ==========================================
  // helpers
  initial begin
    CORE_CLK = 1'b0;
    forever #2 CORE_CLK = ~CORE_CLK;
  end
  always @(posedge CORE_CLK) if (OVERFLOW === 1'b1) n_ovf++;
  task automatic check(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  // scan each digit position and compare its nibble
  task automatic show(input bcs_count_type c);
    logic [3:0] d [3];
    int         t;
    d = '{c.d0, c.d1, c.d2};
    repeat (12) @(posedge CORE_CLK);
    for (int i = 0; i < 3; i++) begin
      t = 0;
      do begin
        @(posedge CORE_CLK);
        #1 t++;
      end while (DIGIT_SEL_N !== ~(3'h1 << i) && t < 40);
      check(DIGIT_SEL_N === ~(3'h1 << i) && BCD_OUT === d[i],
            "digit");
    end
  endtask
  task automatic clear(input int n);
    @(posedge CORE_CLK) COUNT_CLEAR <= 1'b1;
    repeat (n) begin
      @(posedge CORE_CLK);
      #1 check(DIGIT_SEL_N === 3'h7, "selects on in clear");
    end
    @(posedge CORE_CLK) COUNT_CLEAR <= 1'b0;
  endtask
  // ==========================================
  // scenarios
  task automatic t_clear();
    src.pulses(3);
    clear(10);
    repeat (2) @(posedge CORE_CLK);
    #1 check(DIGIT_SEL_N === 3'h6, "first digit");
    check(BCD_OUT === 4'h0, "cleared value");
    $display("done clear");
  endtask
  task automatic t_count();
    src.pulses(12);
    show(bcs_count_type'(12'h012));
    @(posedge CORE_CLK) COUNT_DISABLE <= 1'b1;
    src.pulses(5);
    @(posedge CORE_CLK) COUNT_DISABLE <= 1'b0;
    show(bcs_count_type'(12'h012));
    $display("done count");
  endtask
  task automatic t_capture();
    @(posedge CORE_CLK) CAPTURE_HOLD <= 1'b1;
    src.pulses(7);
    show(bcs_count_type'(12'h012));
    // hold stays high across the whole clear pulse
    clear(3);
    show(bcs_count_type'(12'h012));
    @(posedge CORE_CLK) CAPTURE_HOLD <= 1'b0;
    show(bcs_count_type'(12'h000));
    $display("done capture");
  endtask
  task automatic t_overflow();
    n_ovf = 0;
    src.pulses(999);
    repeat (4) @(posedge CORE_CLK);
    check(n_ovf == 0, "early overflow");
    src.pulses(1);
    repeat (4) @(posedge CORE_CLK);
    check(n_ovf == 1, "overflow count");
    show(bcs_count_type'(12'h000));
    $display("done overflow");
  endtask
  task automatic t_ext();
    logic [2:0] held;
    @(posedge CORE_CLK) SCAN_EXT_SEL <= 1'b1;
    src.pulses(345);
    repeat (4) @(posedge CORE_CLK);
    #1 check(DIGIT_SEL_N !== 3'h7, "selects idle");
    held = DIGIT_SEL_N;
    // 30 internal-rate cycles would move the scanner off this digit
    repeat (30) @(posedge CORE_CLK);
    #1 check(DIGIT_SEL_N === held, "scan held");
    @(posedge CORE_CLK) ext_run <= 1'b1;
    show(bcs_count_type'(12'h345));
    $display("done external scan");
  endtask
  task automatic finish_test();
    $display("checks %0d fails %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ==========================================
  // main sequence and watchdog
  initial begin
    RST_N         = 1'b0;
    COUNT_DISABLE = 1'b0;
    COUNT_CLEAR   = 1'b0;
    CAPTURE_HOLD  = 1'b0;
    SCAN_EXT_SEL  = 1'b0;
    ext_run       = 1'b0;
    repeat (4) @(posedge CORE_CLK);
    #1 check(DIGIT_SEL_N === 3'h7 && OVERFLOW === 1'b0, "reset");
    @(posedge CORE_CLK) RST_N <= 1'b1;
    t_clear();
    t_count();
    t_capture();
    t_overflow();
    t_ext();
    finish_test();
  end
  initial begin
    #(20000 * 4);
    n_fail++;
    finish_test();
  end
endmodule
